// ### rtl/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// Bus widths and array depth.
`define SSR_ADDR_W 19
`define SSR_DEPTH 524288
`define SSR_LANES 4
`define SSR_LANE_W 9
`define SSR_DATA_W 36
`define SSR_BURST_W 2

// Sleep timing, in clock cycles.
`define SSR_ENTRY_CYC 2
`define SSR_WAKE_CYC 2
`define SSR_CTL_WAKE_CYC 8
`define SSR_CNT_W 4

// Reset values of the idle bus.
`define SSR_IDLE_N 1'b1
`define SSR_LANES_IDLE 4'hf

`endif

// ### rtl/ssr_pkg.sv
`include "ssr_cfg.svh"

package ssr_pkg;

  typedef enum logic [1:0] {
    SSR_DEV_AWAKE,
    SSR_DEV_ASLEEP,
    SSR_DEV_WAKING
  } ssr_dev_state_type;

  typedef enum logic [2:0] {
    SSR_CTL_IDLE,
    SSR_CTL_RD_HOLD,
    SSR_CTL_RD_CAPT,
    SSR_CTL_WR_HOLD,
    SSR_CTL_SLEEP,
    SSR_CTL_WAKE
  } ssr_ctl_state_type;

  // The part counts as selected only with first and third low, second high.
  function automatic logic ssr_selected(input logic first_n,
                                        input logic second_hi,
                                        input logic third_n);
    return !first_n && second_hi && !third_n;
  endfunction

  // Lanes written this cycle; all zero means the cycle is a read.
  function automatic logic [`SSR_LANES-1:0] ssr_lane_mask(
    input logic all_n, input logic gate_n,
    input logic [`SSR_LANES-1:0] lane_n);
    if (!all_n)
      return {`SSR_LANES{1'b1}};
    else if (!gate_n)
      return ~lane_n;
    else
      return '0;
  endfunction

  // Burst address from base and count, linear or interleaved order.
  function automatic logic [`SSR_ADDR_W-1:0] ssr_burst_addr(
    input logic [`SSR_ADDR_W-1:0] base,
    input logic [`SSR_BURST_W-1:0] cnt, input logic linear_n);
    logic [`SSR_BURST_W-1:0] low;
    low = linear_n ? (base[`SSR_BURST_W-1:0] ^ cnt)
                   : (base[`SSR_BURST_W-1:0] + cnt);
    return {base[`SSR_ADDR_W-1:`SSR_BURST_W], low};
  endfunction

endpackage : ssr_pkg

// ### rtl/ssr_bus_if.sv
`include "ssr_cfg.svh"

interface ssr_bus_if;
  logic sleep_drive;
  logic sleep_drive_oe;
  logic sleep_request;
  logic [`SSR_ADDR_W-1:0] addr;
  logic processor_address_strobe_n;
  logic controller_address_strobe_n;
  logic adv_n;
  logic global_write_n;
  logic byte_write_gate_n;
  logic [`SSR_LANES-1:0] byte_lane_write_n;
  logic first_select_n;
  logic second_select_high;
  logic third_select_n;
  logic [`SSR_DATA_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [`SSR_DATA_W-1:0] dq_ram;
  logic dq_ram_oe;
  logic [`SSR_DATA_W-1:0] dq;

  // An undriven sleep line is pulled low, leaving the memory awake.
  assign sleep_request = sleep_drive_oe & sleep_drive;
  // Shared data wire; with no driver it settles low.
  assign dq = dq_ram_oe ? dq_ram : (dq_ctl_oe ? dq_ctl : '0);

  modport dev (
    input sleep_request, addr, processor_address_strobe_n,
    input controller_address_strobe_n, adv_n, global_write_n,
    input byte_write_gate_n, byte_lane_write_n, first_select_n,
    input second_select_high, third_select_n, dq,
    output dq_ram, dq_ram_oe
  );

  modport ctl (
    output sleep_drive, sleep_drive_oe, addr, processor_address_strobe_n,
    output controller_address_strobe_n, adv_n,
    output global_write_n, byte_write_gate_n, byte_lane_write_n,
    output first_select_n, second_select_high, third_select_n,
    output dq_ctl, dq_ctl_oe,
    input dq
  );
endinterface : ssr_bus_if

// ### rtl/ssr_sram_dev.sv
`include "ssr_cfg.svh"

module ssr_sram_dev
  import ssr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Static burst order strap, low selects linear order.
  input wire logic BURST_LINEAR_N,
  // Memory bus.
  ssr_bus_if.dev BUS,
  // Status.
  output logic ASLEEP
);

  logic [2:0] sync_r;
  logic sleep_lvl_r;
  logic sleep_lvl_nxt;
  ssr_dev_state_type state_r;
  ssr_dev_state_type state_nxt;
  logic [`SSR_CNT_W-1:0] wake_cnt_r;
  logic [`SSR_CNT_W-1:0] wake_cnt_nxt;
  logic burst_r;
  logic burst_nxt;
  logic [`SSR_ADDR_W-1:0] base_r;
  logic [`SSR_ADDR_W-1:0] base_nxt;
  logic [`SSR_BURST_W-1:0] cnt_r;
  logic [`SSR_BURST_W-1:0] cnt_nxt;
  logic [`SSR_DATA_W-1:0] dout_r;
  logic [`SSR_DATA_W-1:0] dout_nxt;
  logic oe_r;
  logic oe_nxt;
  logic asleep_r;
  logic asleep_nxt;
  logic linear_n_r;
  logic proc_live;
  logic start;
  logic sel;
  logic access;
  logic [`SSR_LANES-1:0] lane_mask;
  logic [`SSR_LANES-1:0] wr_en;
  logic [`SSR_ADDR_W-1:0] acc_addr;
  logic [`SSR_DATA_W-1:0] rd_word;

  // The sleep pin crosses in through three stages.
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync_r <= 3'h0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], BUS.sleep_request};
    end
  end

  always_comb
  begin
    // The filtered level moves only when the last two stages agree.
    sleep_lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : sleep_lvl_r;
    // Processor strobe is blocked while the first select is high.
    proc_live = !BUS.processor_address_strobe_n && !BUS.first_select_n;
    start = proc_live || !BUS.controller_address_strobe_n;
    sel = ssr_selected(BUS.first_select_n, BUS.second_select_high,
                       BUS.third_select_n);
    lane_mask = ssr_lane_mask(BUS.global_write_n, BUS.byte_write_gate_n,
                              BUS.byte_lane_write_n);
    state_nxt = state_r;
    wake_cnt_nxt = wake_cnt_r;
    burst_nxt = burst_r;
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    dout_nxt = dout_r;
    oe_nxt = 1'b0;
    wr_en = '0;
    access = 1'b0;
    acc_addr = ssr_burst_addr(base_r, cnt_r, linear_n_r);
    case (state_r)
      SSR_DEV_AWAKE:
      begin
        // The synchroniser delay keeps sampling for two edges or more.
        if (sleep_lvl_r)
        begin
          state_nxt = SSR_DEV_ASLEEP;
          burst_nxt = 1'b0;
        end
        else if (start)
        begin
          if (sel)
          begin
            burst_nxt = 1'b1;
            base_nxt = BUS.addr;
            cnt_nxt = '0;
            acc_addr = BUS.addr;
            access = 1'b1;
            // A processor strobe always begins a read.
            if (!proc_live)
            begin
              wr_en = lane_mask;
            end
          end
          else
          begin
            burst_nxt = 1'b0;
          end
        end
        // A suspended burst holds its address and leaves the data lines free.
        else if (burst_r && !BUS.adv_n)
        begin
          access = 1'b1;
          if (!BUS.adv_n)
          begin
            cnt_nxt = cnt_r + 1'b1;
            acc_addr = ssr_burst_addr(base_r, cnt_nxt, linear_n_r);
          end
          wr_en = lane_mask;
        end
        if (access && (wr_en == '0))
        begin
          dout_nxt = rd_word;
          oe_nxt = 1'b1;
        end
      end
      SSR_DEV_ASLEEP:
      begin
        // Every synchronous input is ignored and the part stays deselected.
        burst_nxt = 1'b0;
        if (!sleep_lvl_r)
        begin
          state_nxt = SSR_DEV_WAKING;
          wake_cnt_nxt = '0;
        end
      end
      SSR_DEV_WAKING:
      begin
        burst_nxt = 1'b0;
        if (sleep_lvl_r)
        begin
          state_nxt = SSR_DEV_ASLEEP;
        end
        else if (wake_cnt_r == `SSR_CNT_W'(`SSR_WAKE_CYC - 1))
        begin
          state_nxt = SSR_DEV_AWAKE;
        end
        else
        begin
          wake_cnt_nxt = wake_cnt_r + 1'b1;
        end
      end
      default:
      begin
        state_nxt = SSR_DEV_AWAKE;
        burst_nxt = 1'b0;
      end
    endcase
    asleep_nxt = (state_nxt != SSR_DEV_AWAKE);
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sleep_lvl_r <= 1'b0;
      state_r <= SSR_DEV_AWAKE;
      wake_cnt_r <= '0;
      burst_r <= 1'b0;
      base_r <= '0;
      cnt_r <= '0;
      dout_r <= '0;
      asleep_r <= 1'b0;
      linear_n_r <= 1'b0;
    end
    else
    begin
      sleep_lvl_r <= sleep_lvl_nxt;
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      burst_r <= burst_nxt;
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
      asleep_r <= asleep_nxt;
      linear_n_r <= BURST_LINEAR_N;
    end
  end

  // The sleep pin drops the data drivers at once, without the clock.
  always_ff @(posedge CLK or negedge RSTN or posedge BUS.sleep_request)
  begin
    if (!RSTN)
    begin
      oe_r <= 1'b0;
    end
    else if (BUS.sleep_request)
    begin
      oe_r <= 1'b0;
    end
    else
    begin
      oe_r <= oe_nxt;
    end
  end

  // One storage array per byte lane.
  generate
    for (genvar g = 0; g < `SSR_LANES; g++)
    begin : g_lane
      logic [`SSR_LANE_W-1:0] mem [0:`SSR_DEPTH-1];

      always_ff @(posedge CLK)
      begin
        if (wr_en[g])
        begin
          mem[acc_addr] <= BUS.dq[g*`SSR_LANE_W +: `SSR_LANE_W];
        end
      end

      assign rd_word[g*`SSR_LANE_W +: `SSR_LANE_W] = mem[acc_addr];
    end
  endgenerate

  assign BUS.dq_ram = dout_r;
  assign BUS.dq_ram_oe = oe_r;
  assign ASLEEP = asleep_r;

endmodule // ssr_sram_dev

// ### rtl/ssr_sram_ctl.sv
// Design decisions made here: the address map and the address-and-strobe port.
`include "ssr_cfg.svh"

module ssr_sram_ctl
  import ssr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Access requests.
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [`SSR_ADDR_W-1:0] REQ_ADDR,
  input wire logic [`SSR_DATA_W-1:0] REQ_WDATA,
  input wire logic [`SSR_LANES-1:0] REQ_LANES,
  output logic REQ_READY,
  // Read answers.
  output logic RSP_VALID,
  output logic [`SSR_DATA_W-1:0] RSP_RDATA,
  // Sleep control.
  input wire logic SLEEP_CMD,
  output logic SLEEP_ACTIVE,
  // Memory bus.
  ssr_bus_if.ctl BUS
);

  ssr_ctl_state_type state_r;
  ssr_ctl_state_type state_nxt;
  logic [`SSR_CNT_W-1:0] cnt_r;
  logic [`SSR_CNT_W-1:0] cnt_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic sleep_oe_r;
  logic proc_stb_n_r;
  logic proc_stb_n_nxt;
  logic ctl_stb_n_r;
  logic ctl_stb_n_nxt;
  logic sel_n_r;
  logic sel_n_nxt;
  logic sel_hi_r;
  logic sel_hi_nxt;
  logic all_wr_n_r;
  logic all_wr_n_nxt;
  logic gate_n_r;
  logic gate_n_nxt;
  logic [`SSR_LANES-1:0] lane_n_r;
  logic [`SSR_LANES-1:0] lane_n_nxt;
  logic [`SSR_ADDR_W-1:0] addr_r;
  logic [`SSR_ADDR_W-1:0] addr_nxt;
  logic [`SSR_DATA_W-1:0] dout_r;
  logic [`SSR_DATA_W-1:0] dout_nxt;
  logic doe_r;
  logic doe_nxt;
  logic ready_r;
  logic ready_nxt;
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  logic [`SSR_DATA_W-1:0] rsp_data_r;
  logic [`SSR_DATA_W-1:0] rsp_data_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sleep_nxt = sleep_r;
    proc_stb_n_nxt = `SSR_IDLE_N;
    ctl_stb_n_nxt = `SSR_IDLE_N;
    sel_n_nxt = `SSR_IDLE_N;
    sel_hi_nxt = 1'b0;
    all_wr_n_nxt = `SSR_IDLE_N;
    gate_n_nxt = `SSR_IDLE_N;
    lane_n_nxt = `SSR_LANES_IDLE;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    doe_nxt = 1'b0;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    case (state_r)
      SSR_CTL_IDLE:
      begin
        if (REQ_VALID && ready_r)
        begin
          addr_nxt = REQ_ADDR;
          // All selects go active with every strobe.
          sel_n_nxt = 1'b0;
          sel_hi_nxt = 1'b1;
          if (REQ_WRITE)
          begin
            ctl_stb_n_nxt = 1'b0;
            if (&REQ_LANES)
            begin
              all_wr_n_nxt = 1'b0;
            end
            else
            begin
              gate_n_nxt = 1'b0;
              lane_n_nxt = ~REQ_LANES;
            end
            dout_nxt = REQ_WDATA;
            doe_nxt = 1'b1;
            state_nxt = SSR_CTL_WR_HOLD;
          end
          else
          begin
            proc_stb_n_nxt = 1'b0;
            state_nxt = SSR_CTL_RD_HOLD;
          end
        end
        else if (SLEEP_CMD)
        begin
          // Sleep is raised only with no access outstanding.
          sleep_nxt = 1'b1;
          state_nxt = SSR_CTL_SLEEP;
        end
      end
      SSR_CTL_WR_HOLD:
      begin
        state_nxt = SSR_CTL_IDLE;
      end
      SSR_CTL_RD_HOLD:
      begin
        state_nxt = SSR_CTL_RD_CAPT;
      end
      SSR_CTL_RD_CAPT:
      begin
        rsp_data_nxt = BUS.dq;
        rsp_valid_nxt = 1'b1;
        state_nxt = SSR_CTL_IDLE;
      end
      SSR_CTL_SLEEP:
      begin
        if (!SLEEP_CMD)
        begin
          sleep_nxt = 1'b0;
          cnt_nxt = '0;
          state_nxt = SSR_CTL_WAKE;
        end
      end
      SSR_CTL_WAKE:
      begin
        // Strobes stay high and no write starts until the wait ends.
        if (cnt_r == `SSR_CNT_W'(`SSR_CTL_WAKE_CYC - 1))
        begin
          state_nxt = SSR_CTL_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default:
      begin
        state_nxt = SSR_CTL_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == SSR_CTL_IDLE);
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_r <= SSR_CTL_IDLE;
      cnt_r <= '0;
      sleep_r <= 1'b0;
      sleep_oe_r <= 1'b0;
      proc_stb_n_r <= `SSR_IDLE_N;
      ctl_stb_n_r <= `SSR_IDLE_N;
      sel_n_r <= `SSR_IDLE_N;
      sel_hi_r <= 1'b0;
      all_wr_n_r <= `SSR_IDLE_N;
      gate_n_r <= `SSR_IDLE_N;
      lane_n_r <= `SSR_LANES_IDLE;
      addr_r <= '0;
      dout_r <= '0;
      doe_r <= 1'b0;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sleep_r <= sleep_nxt;
      sleep_oe_r <= 1'b1;
      proc_stb_n_r <= proc_stb_n_nxt;
      ctl_stb_n_r <= ctl_stb_n_nxt;
      sel_n_r <= sel_n_nxt;
      sel_hi_r <= sel_hi_nxt;
      all_wr_n_r <= all_wr_n_nxt;
      gate_n_r <= gate_n_nxt;
      lane_n_r <= lane_n_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      ready_r <= ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

  assign BUS.sleep_drive = sleep_r;
  assign BUS.sleep_drive_oe = sleep_oe_r;
  assign BUS.addr = addr_r;
  assign BUS.processor_address_strobe_n = proc_stb_n_r;
  assign BUS.controller_address_strobe_n = ctl_stb_n_r;
  assign BUS.adv_n = `SSR_IDLE_N;
  assign BUS.global_write_n = all_wr_n_r;
  assign BUS.byte_write_gate_n = gate_n_r;
  assign BUS.byte_lane_write_n = lane_n_r;
  assign BUS.first_select_n = sel_n_r;
  assign BUS.second_select_high = sel_hi_r;
  assign BUS.third_select_n = sel_n_r;
  assign BUS.dq_ctl = dout_r;
  assign BUS.dq_ctl_oe = doe_r;
  assign REQ_READY = ready_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_RDATA = rsp_data_r;
  assign SLEEP_ACTIVE = sleep_r;

endmodule // ssr_sram_ctl

// ### test/ssr_checker.sv
`include "ssr_cfg.svh"

module ssr_checker (
  // Clock and reset.
  input logic CLK,
  input logic RSTN,
  // Memory bus signals.
  input logic sleep_request,
  input logic sleep_drive_oe,
  input logic proc_stb_n,
  input logic ctl_stb_n,
  input logic global_write_n,
  input logic byte_write_gate_n,
  input logic [`SSR_LANES-1:0] byte_lane_write_n,
  input logic first_select_n,
  input logic second_select_high,
  input logic third_select_n,
  input logic dq_ctl_oe,
  input logic dq_ram_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic wr;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // Select and write decode of the sampled bus.
  assign sel = !first_select_n && second_select_high && !third_select_n;
  assign wr = !global_write_n ||
              (!byte_write_gate_n && byte_lane_write_n != `SSR_LANES_IDLE);

  a_asleep_highz: assert property (
    sleep_request |-> !dq_ram_oe)
    else $error("Memory drives data while asleep.");
  a_wake_strobes_idle: assert property (
    $fell(sleep_request) |-> (proc_stb_n && ctl_stb_n) [*3])
    else $error("Strobe asserted just after wake.");
  a_wake_no_write: assert property (
    $fell(sleep_request) |-> (global_write_n && byte_write_gate_n) [*3])
    else $error("Write started in wake window.");
  a_sleep_after_done: assert property (
    $rose(sleep_request) |->
      proc_stb_n && ctl_stb_n && !dq_ctl_oe && !dq_ram_oe)
    else $error("Sleep raised with access pending.");
  a_strobe_selects: assert property (
    (!proc_stb_n || !ctl_stb_n) |-> sel)
    else $error("Strobe without all selects.");
  a_read_drives: assert property (
    (!proc_stb_n && sel && !sleep_request) |=> dq_ram_oe)
    else $error("Read access gave no data.");
  a_write_quiet: assert property (
    (!ctl_stb_n && sel && wr) |=> !dq_ram_oe)
    else $error("Memory drove data on a write.");
  a_wake_no_burst: assert property (
    $fell(sleep_request) |-> !dq_ram_oe [*4])
    else $error("Burst continued after wake.");
  a_sleep_pulldown: assert property (
    disable iff (1'b0) !sleep_drive_oe |-> !sleep_request)
    else $error("Undriven sleep line not low.");

  c_read: cover property (!proc_stb_n && sel ##1 dq_ram_oe);
  c_lane_write: cover property (!ctl_stb_n && global_write_n && wr);
  c_sleep_in: cover property ($rose(sleep_request));
  c_sleep_out: cover property ($fell(sleep_request));
endmodule // ssr_checker

// ### test/tb.sv
`include "ssr_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rstn;
  logic req_valid;
  logic req_write;
  logic [`SSR_ADDR_W-1:0] req_addr;
  logic [`SSR_DATA_W-1:0] req_wdata;
  logic [`SSR_LANES-1:0] req_lanes;
  logic req_ready;
  logic rsp_valid;
  logic [`SSR_DATA_W-1:0] rsp_rdata;
  logic sleep_cmd;
  logic sleep_active;
  logic asleep;
  int n_errors;
  int checks;
  int cyc;

  ssr_bus_if ssr_bus_if_i ();

  ssr_sram_dev ssr_sram_dev_i (.CLK(clk), .RSTN(rstn),
    .BURST_LINEAR_N(1'b0), .BUS(ssr_bus_if_i), .ASLEEP(asleep));

  ssr_sram_ctl ssr_sram_ctl_i (.CLK(clk), .RSTN(rstn),
    .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_LANES(req_lanes), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .SLEEP_CMD(sleep_cmd),
    .SLEEP_ACTIVE(sleep_active), .BUS(ssr_bus_if_i));

  ssr_checker ssr_checker_i (.CLK(clk), .RSTN(rstn),
    .sleep_request(ssr_bus_if_i.sleep_request),
    .sleep_drive_oe(ssr_bus_if_i.sleep_drive_oe),
    .proc_stb_n(ssr_bus_if_i.processor_address_strobe_n),
    .ctl_stb_n(ssr_bus_if_i.controller_address_strobe_n),
    .global_write_n(ssr_bus_if_i.global_write_n),
    .byte_write_gate_n(ssr_bus_if_i.byte_write_gate_n),
    .byte_lane_write_n(ssr_bus_if_i.byte_lane_write_n),
    .first_select_n(ssr_bus_if_i.first_select_n),
    .second_select_high(ssr_bus_if_i.second_select_high),
    .third_select_n(ssr_bus_if_i.third_select_n),
    .dq_ctl_oe(ssr_bus_if_i.dq_ctl_oe), .dq_ram_oe(ssr_bus_if_i.dq_ram_oe));

  always #25 clk = ~clk;

  task conclude;
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      conclude;
    end
  end

  task cmp(input logic [`SSR_DATA_W-1:0] got,
           input logic [`SSR_DATA_W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Presents one request and holds it until the edge that takes it.
  task req(input logic w, input logic [`SSR_ADDR_W-1:0] a,
           input logic [`SSR_DATA_W-1:0] d, input logic [3:0] l,
           input logic s);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    sleep_cmd <= s;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 40);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task rd_chk(input logic [`SSR_ADDR_W-1:0] a,
              input logic [`SSR_DATA_W-1:0] exp, input logic s);
    int n;
    req(1'b0, a, '0, 4'h0, s);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    cmp(rsp_rdata, exp);
  endtask

  task t_reset;
    @(negedge clk);
    cmp({35'h0, ssr_bus_if_i.sleep_request}, 36'h0);
    cmp({35'h0, asleep}, 36'h0);
  endtask

  task t_lanes;
    logic [`SSR_DATA_W-1:0] exp;
    logic [`SSR_DATA_W-1:0] d;
    logic [`SSR_DATA_W-1:0] m;
    exp = 36'h123456789;
    req(1'b1, 19'h00010, exp, 4'hf, 1'b0);
    rd_chk(19'h00010, exp, 1'b0);
    for (int g = 0; g < 4; g++)
    begin
      d = {4{9'h1a5 + 9'(g)}};
      m = 36'h1ff << (9 * g);
      exp = (exp & ~m) | (d & m);
      req(1'b1, 19'h00010, d, 4'h1 << g, 1'b0);
      rd_chk(19'h00010, exp, 1'b0);
    end
    req(1'b1, 19'h00010, '1, 4'h0, 1'b0);
    rd_chk(19'h00010, exp, 1'b0);
  endtask

  task t_sleep;
    int n;
    req(1'b1, 19'h00020, 36'h0a5a5a5a5, 4'hf, 1'b0);
    rd_chk(19'h00020, 36'h0a5a5a5a5, 1'b1);
    n = 0;
    while (ssr_bus_if_i.sleep_request !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (asleep !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    cmp({35'h0, sleep_active}, 36'h1);
    cmp({35'h0, n >= 2 && n <= 6}, 36'h1);
    repeat (4)
    begin
      @(negedge clk);
      cmp({34'h0, asleep, ssr_bus_if_i.dq_ram_oe}, 36'h2);
    end
    @(posedge clk);
    sleep_cmd <= 1'b0;
    n = 0;
    while (ssr_bus_if_i.sleep_request !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (asleep !== 1'b0 && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    cmp({34'h0, sleep_active, req_ready}, 36'h0);
    cmp({35'h0, n >= 2 && n <= 8}, 36'h1);
    req(1'b1, 19'h00021, 36'h5a5a5a5a5, 4'hf, 1'b0);
    rd_chk(19'h00021, 36'h5a5a5a5a5, 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_lanes = 4'h0;
    sleep_cmd = 1'b0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    @(posedge clk);
    t_reset;
    @(posedge clk);
    rstn <= 1'b1;
    t_lanes;
    t_sleep;
    conclude;
  end
endmodule // tb
